// ===== core/xdpc_checker.sv
module xdpc_checker
    import xdpc_pkg::*;
#(
    parameter bit NX_CAPABLE = 1'b1,
    parameter bit LM_CAPABLE = 1'b1,
    parameter logic [1:0] PA_WIDTH_SEL = 2'h0
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic paging_enable,
    input wire logic physical_address_extension,
    input wire logic page_size_extension,
    input wire logic write_protect,
    input wire logic long_mode_on,
    input wire logic req_valid,
    input wire xdpc_req_t req,
    output logic rsp_valid,
    output xdpc_rsp_t rsp,
    output logic general_protection_fault,
    output logic nx_active
);
    logic [63:0] efe_q;
    logic [63:0] efe_d;
    logic gp_q;
    logic gp_d;
    logic rsp_valid_q;
    xdpc_rsp_t rsp_q;
    xdpc_rsp_t rsp_d;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic nx_q;
    logic [7:0] stat_q;
    logic [7:0] stat_d;

    // Bus decode; every access completes in its second access cycle, after one wait state
    wire logic acc = psel && penable && !pready_q;
    wire logic wr = acc && pwrite;
    wire logic hit_lo = paddr == XDPC_ADDR_EFE_LO;
    wire logic hit_hi = paddr == XDPC_ADDR_EFE_HI;
    wire logic hit_id = paddr == XDPC_ADDR_IDENT;
    wire logic hit_st = paddr == XDPC_ADDR_STATUS;
    wire logic mapped = hit_lo || hit_hi || hit_id || hit_st;

    wire logic [31:0] ident = ({31'h0, NX_CAPABLE} << XDPC_ID_NX_BIT) | ({31'h0, LM_CAPABLE} << XDPC_ID_LM_BIT);
    wire logic efe_exists = ident[XDPC_ID_NX_BIT] || ident[XDPC_ID_LM_BIT];

    wire logic nx_en_wr = wr && hit_lo && efe_exists && pstrb[1] && pwdata[XDPC_BIT_NX_EN];
    wire logic gp_hit = nx_en_wr && !NX_CAPABLE;
    wire logic [63:0] wmask = NX_CAPABLE ? XDPC_EFE_WMASK : (XDPC_EFE_WMASK & ~(64'h1 << XDPC_BIT_NX_EN));
    wire logic [31:0] bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire logic [63:0] wval = {32'h0, pwdata & bmask};
    wire logic [63:0] lo_mask = wmask & {32'h0, bmask};

    // writable fields; active flag follows paging with long enable
    always_comb
    begin
        efe_d = efe_q;
        if (wr && hit_lo && efe_exists && !gp_hit)
        begin
            efe_d = (efe_q & ~lo_mask) | (wval & lo_mask);
        end
        efe_d[XDPC_BIT_LONG_ACT] = efe_d[XDPC_BIT_LONG_EN] && paging_enable && LM_CAPABLE;
    end

    wire logic nx_en = efe_q[XDPC_BIT_NX_EN];
    wire logic in_long = long_mode_on && efe_q[XDPC_BIT_LONG_ACT];
    wire xdpc_mode_t mode = in_long ? XDPC_MODE_LONG : physical_address_extension ? XDPC_MODE_EXT :
        page_size_extension ? XDPC_MODE_LARGE36 : XDPC_MODE_SMALL;
    wire logic nx_on = nx_en && paging_enable && (mode == XDPC_MODE_EXT || mode == XDPC_MODE_LONG);

    wire logic big = req.dir[7];
    wire logic xd_long = req.lvl4[XDPC_XD_BIT] | req.ptr[XDPC_XD_BIT] | req.dir[XDPC_XD_BIT] | req.leaf[XDPC_XD_BIT];
    wire logic xd_ext = req.dir[XDPC_XD_BIT] | (!big & req.leaf[XDPC_XD_BIT]);
    wire logic xd = (mode == XDPC_MODE_LONG) ? xd_long : xd_ext;
    // fetch fault on translation cache fill
    wire logic nx_fault = nx_on && req.fetch && req.itc_miss && xd;

    wire logic [63:0] pa_extra = (PA_WIDTH_SEL == XDPC_PA_36) ? XDPC_RSV_39_36 :
        (PA_WIDTH_SEL == XDPC_PA_32) ? XDPC_RSV_39_32 : 64'h0;
    wire logic [63:0] ext_hi = (nx_en ? XDPC_RSV_62_40 : XDPC_RSV_63_40) | pa_extra;
    wire logic [63:0] lng_hi = nx_en ? XDPC_RSV_51_40 : (XDPC_RSV_51_40 | XDPC_RSV_63);
    wire logic [63:0] big_m = big ? XDPC_RSV_2M : 64'h0;
    wire logic rsv_ext = |(req.ptr & (XDPC_RSV_63_40 | pa_extra | XDPC_RSV_PTR)) |
        |(req.dir & (ext_hi | big_m)) | (!big && |(req.leaf & ext_hi));
    wire logic rsv_lng = |(req.lvl4 & lng_hi) | |(req.ptr & lng_hi) | |(req.dir & (lng_hi | big_m)) |
        (!big && |(req.leaf & lng_hi));
    // 36-bit large-page mode checks only bit 21
    wire logic rsv_l36 = big && |(req.dir & XDPC_RSV_4M);
    wire logic rsv = paging_enable && ((mode == XDPC_MODE_EXT && rsv_ext) ||
        (mode == XDPC_MODE_LONG && rsv_lng) || (mode == XDPC_MODE_LARGE36 && rsv_l36));

    wire logic user = req.current_privilege_level == 2'h3;
    // combined user and write flags of both levels
    wire logic pg_user = req.dir[2] && (big || req.leaf[2]);
    wire logic pg_rw = req.dir[1] && (big || req.leaf[1]);
    wire logic wr_ok = pg_rw || (!user && !write_protect);
    wire logic prot_fault = paging_enable && ((user && !pg_user) || (req.write && !wr_ok));

    always_comb
    begin
        rsp_d.rsv_fault = rsv;
        rsp_d.page_fault = rsv || nx_fault || prot_fault;
        rsp_d.allow = !rsp_d.page_fault;
        rsp_d.install = req.itc_miss && !rsp_d.page_fault;
    end

    // Status: mode, gate, sticky fault seen; the set beats clearing via write
    always_comb
    begin
        stat_d = {4'h0, stat_q[3], nx_on, mode};
        if (wr && hit_st && pstrb[0] && pwdata[3])
        begin
            stat_d[3] = 1'b0;
        end
        if (gp_hit)
        begin
            stat_d[3] = 1'b1;
        end
    end

    wire logic [31:0] rd_mux = hit_lo ? efe_q[31:0] : hit_hi ? efe_q[63:32] : hit_id ? ident : {24'h0, stat_q};

    // Registers
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            efe_q <= XDPC_EFE_RESET;
            gp_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_q <= '0;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            nx_q <= 1'b0;
            stat_q <= 8'h00;
        end
        else
        begin
            efe_q <= efe_d;
            gp_q <= gp_hit;
            rsp_valid_q <= req_valid;
            rsp_q <= req_valid ? rsp_d : '0;
            prdata_q <= (acc && !pwrite && mapped) ? rd_mux : 32'h0000_0000;
            pready_q <= acc;
            pslverr_q <= acc && (!mapped || gp_hit);
            nx_q <= nx_on;
            stat_q <= stat_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp = rsp_q;
    assign general_protection_fault = gp_q;
    assign nx_active = nx_q;
endmodule

// ===== core/xdpc_pkg.sv
// Function
// - Execute-disabled page faults on instruction fetch
// - Enforce only with enable bit and extension
// - User and write checks still apply while paging is on
// - Only extended-address protected mode or long mode
// - Identification leaf bit 20 reports capability
// - Feature register exists if bit 20/29
// - Enable write without capability: protection fault
// - Register fields at bits 0, 8, 10, 11
// - Bit 63 at any level makes data-only
// - Long mode checks all four levels
// - Legacy extended mode: directory plus leaf
// - Write-protect control governs supervisor writes
// - Paging mode selected from control bits
// - Large-page flag selects 4KB or 2MB
// - 36-bit large-page checks bit 21 only
// - Extended-address reserved bits with enable set
// - Long mode reserved bits 51:40, 20:13
// - Without enable, bit 63 also reserved
// - Fault on any fetch, any privilege
// - Evaluate only on translation cache miss fill
// - Levels 0-2 supervisor, 3 user
// - Checks complete before memory cycle
package xdpc_pkg;
    localparam logic [11:0] XDPC_ADDR_EFE_LO = 12'h000;
    localparam logic [11:0] XDPC_ADDR_EFE_HI = 12'h004;
    localparam logic [11:0] XDPC_ADDR_IDENT = 12'h008;
    localparam logic [11:0] XDPC_ADDR_STATUS = 12'h00C;
    localparam int XDPC_BIT_SYSCALL = 0;
    localparam int XDPC_BIT_LONG_EN = 8;
    localparam int XDPC_BIT_LONG_ACT = 10;
    localparam int XDPC_BIT_NX_EN = 11;
    localparam int XDPC_ID_NX_BIT = 20;
    localparam int XDPC_ID_LM_BIT = 29;
    localparam int XDPC_XD_BIT = 63;
    localparam logic [63:0] XDPC_EFE_RESET = 64'h0000_0000_0000_0000;
    localparam logic [63:0] XDPC_EFE_WMASK = 64'h0000_0000_0000_0901;
    localparam logic [63:0] XDPC_RSV_63_40 = 64'hFFFF_FF00_0000_0000;
    localparam logic [63:0] XDPC_RSV_62_40 = 64'h7FFF_FF00_0000_0000;
    localparam logic [63:0] XDPC_RSV_51_40 = 64'h000F_FF00_0000_0000;
    localparam logic [63:0] XDPC_RSV_63 = 64'h8000_0000_0000_0000;
    localparam logic [63:0] XDPC_RSV_PTR = 64'h0000_0000_0000_01E6;
    localparam logic [63:0] XDPC_RSV_2M = 64'h0000_0000_001F_E000;
    localparam logic [63:0] XDPC_RSV_4M = 64'h0000_0000_0020_0000;
    localparam logic [63:0] XDPC_RSV_39_36 = 64'h0000_00F0_0000_0000;
    localparam logic [63:0] XDPC_RSV_39_32 = 64'h0000_00FF_0000_0000;
    localparam logic [1:0] XDPC_PA_40 = 2'h0;
    localparam logic [1:0] XDPC_PA_36 = 2'h1;
    localparam logic [1:0] XDPC_PA_32 = 2'h2;
    typedef enum logic [1:0] {XDPC_MODE_SMALL, XDPC_MODE_LARGE36, XDPC_MODE_EXT, XDPC_MODE_LONG} xdpc_mode_t;
    // One walked translation presented by the walker
    typedef struct packed {
        logic [63:0] lvl4;
        logic [63:0] ptr;
        logic [63:0] dir;
        logic [63:0] leaf;
        logic fetch;
        logic write;
        logic [1:0] current_privilege_level;
        logic itc_miss;
    } xdpc_req_t;
    typedef struct packed {
        logic allow;
        logic page_fault;
        logic rsv_fault;
        logic install;
    } xdpc_rsp_t;
endpackage

// ===== tb/execute_disable_page_checker_test.sv
module execute_disable_page_checker_test
    import xdpc_pkg::*;
;
    timeunit 1ns / 100ps;
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
    localparam logic [63:0] E = 64'h7, NX = 64'h8000_0000_0000_0000;
    logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rsp_valid, req_valid;
    logic paging_enable = 1'b0, physical_address_extension = 1'b0, page_size_extension = 1'b0, write_protect = 1'b0;
    logic long_mode_on = 1'b0, general_protection_fault, nx_active;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] got;
    xdpc_req_t req;
    xdpc_rsp_t rsp;
    int n_mismatch = 0, checked = 0;
    xdpc_checker dut (.*, .pstrb(4'hF));
    xdpc_walker_model walk (.*);
    // Core clock, 4 ns
    initial forever #2 clock = ~clock;
    // APB transfer; compares {pslverr, read data} at the edge pready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
        @(posedge clock);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        // No assumed latency; only the watchdog ends a hung transfer
        while (pready !== 1'b1)
            @(posedge clock);
        `CHK("apb", x, {pslverr, wr ? 32'h0 : prdata})
        {psel, penable} <= 2'h0;
    endtask
    // One walk, compared as {valid, allow, fault, reserved}
    task automatic run(input logic [63:0] l4, dr, lf, input logic [4:0] c, input logic [2:0] x);
        walk.send({l4, long_mode_on ? E : 64'h1, dr, lf, c}, got);
        `CHK("rsp", {1'b1, x}, got)
    endtask
    task automatic give_verdict();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Watchdog; the tests need about 0.4 us
    initial
    begin
        #20000 n_mismatch++;
        give_verdict();
    end
    // Tests
    initial
    begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        apb(1'b0, XDPC_ADDR_IDENT, 32'h0, 33'h0_2010_0000);
        apb(1'b0, 12'h010, 32'h0, 33'h1_0000_0000);
        apb(1'b1, XDPC_ADDR_EFE_LO, 32'hFFFF_FFFF, 33'h0);
        `CHK("gp", 1'b0, general_protection_fault)
        apb(1'b0, XDPC_ADDR_EFE_LO, 32'h0, 33'h0_0000_0901);
        {paging_enable, physical_address_extension} <= 2'h3;
        apb(1'b0, XDPC_ADDR_STATUS, 32'h0, 33'h0_0000_0006);
        `CHK("nx", 1'b1, nx_active)
        run(E, NX | E, E, 5'h11, 3'h2);
        run(E, E, NX | E, 5'h11, 3'h2);
        run(E, 64'h87, NX | E, 5'h11, 3'h4);
        run(E, NX | E, E, 5'h10, 3'h4);
        run(E, 64'h3, E, 5'h07, 3'h2);
        run(E, E, 64'h5, 5'h09, 3'h4);
        write_protect <= 1'b1;
        run(E, E, 64'h5, 5'h09, 3'h2);
        long_mode_on <= 1'b1;
        apb(1'b0, XDPC_ADDR_STATUS, 32'h0, 33'h0_0000_0007);
        run(NX | E, E, E, 5'h11, 3'h2);
        run(E | 64'h0000_2000_0000_0000, E, E, 5'h01, 3'h3);
        // Large-page and small-page modes: no execute gate; bit 21 reserved only in large-page mode
        {long_mode_on, physical_address_extension, page_size_extension} <= 3'h1;
        apb(1'b0, XDPC_ADDR_STATUS, 32'h0, 33'h0_0000_0001);
        `CHK("nx", 1'b0, nx_active)
        run(E, NX | E, E, 5'h11, 3'h4);
        run(E, 64'h0020_0087, E, 5'h01, 3'h3);
        page_size_extension <= 1'b0;
        run(E, 64'h0020_0087, E, 5'h01, 3'h4);
        // Enable cleared: bit 63 becomes a reserved bit
        apb(1'b1, XDPC_ADDR_EFE_LO, 32'h0000_0101, 33'h0);
        physical_address_extension <= 1'b1;
        run(E, E, NX | E, 5'h01, 3'h3);
        `CHK("nx", 1'b0, nx_active)
        long_mode_on <= 1'b1;
        run(NX | E, E, E, 5'h11, 3'h3);
        give_verdict();
    end
endmodule

// ===== tb/xdpc_checker_assertions.sv
module xdpc_checker_assertions
    import xdpc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic paging_enable,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic req_valid,
    input wire xdpc_req_t req,
    input wire logic rsp_valid,
    input wire xdpc_rsp_t rsp,
    input wire logic nx_active
);
    timeunit 1ns / 100ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_wait; psel && penable && !pready; endsequence
    // Answer timing first, then the verdict that each walk must carry
    chk_apb_answer: assert property (s_wait |=> pready)
        else $error("pready late");
    chk_apb_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    chk_rsp_next: assert property (req_valid |=> rsp_valid)
        else $error("no response");
    chk_rsp_quiet: assert property (!req_valid |=> !rsp_valid && rsp == '0)
        else $error("stray response");
    chk_xd_fetch: assert property (req_valid && nx_active && req.fetch && req.itc_miss && req.dir[63]
        |=> rsp.page_fault)
        else $error("fetch from data page");
    // Protection checks only bite while paging is on
    chk_user_page: assert property (req_valid && paging_enable && req.current_privilege_level == 2'h3
        && !req.dir[2] |=> rsp.page_fault)
        else $error("user on supervisor page");
    chk_rsv_block: assert property (rsp.rsv_fault |-> rsp.page_fault && !rsp.install)
        else $error("reserved fault installed");
    chk_one_verdict: assert property (rsp_valid |-> rsp.allow != rsp.page_fault)
        else $error("verdict split");
    chk_install_fill: assert property (req_valid
        |=> rsp.install == ($past(req.itc_miss) && !rsp.page_fault))
        else $error("install mismatch");
endmodule
bind xdpc_checker xdpc_checker_assertions u_chk (.*);

// ===== tb/xdpc_walker_model.sv
module xdpc_walker_model
    import xdpc_pkg::*;
(
    input wire logic clock,
    input wire logic rsp_valid,
    input wire xdpc_rsp_t rsp,
    output logic req_valid,
    output xdpc_req_t req
);
    timeunit 1ns / 100ps;
    initial {req_valid, req} = '0;
    // One walk per call; the bus is inverted after so a stale entry never looks live
    task automatic send(input xdpc_req_t r, output logic [3:0] got);
        @(posedge clock);
        {req_valid, req} <= {1'b1, r};
        @(posedge clock);
        {req_valid, req} <= {1'b0, ~r};
        // The verdict stands one cycle; take it at the edge that closes that cycle
        @(posedge clock);
        got = {rsp_valid, rsp.allow, rsp.page_fault, rsp.rsv_fault};
    endtask
endmodule
